// [wkdet_top.sv]
// Wake input detector top: sync, filter, mode actions, bias
`timescale 1ns/10ps
`default_nettype none
`include "wkdet_consts.svh"
module wkdet_top
	import wkdet_pkg::*;
#(
	parameter int FILTER_CYC = `WKDET_FILTER_CYC
) (
	input  wire logic       CLK,
	input  wire logic       RST_N,
	input  wire logic       WAKE_PIN,
	input  wire logic [1:0] POWER_MODE,
	input  wire logic       WAKE_PIN_ENABLE,
	input  wire logic       CYCLIC_SENSE,
	input  wire logic       CYCLIC_WINDOW,
	input  wire logic       BUCK_MODE_BY_PIN_SEL,
	input  wire logic       BIAS_SELECT_HIGH_BIT,
	input  wire logic       BIAS_SELECT_LOW_BIT,
	input  wire logic       WAKE_FLAG_CLEAR,
	output logic            WAKE_PIN_EVENT_FLAG,
	output logic            WAKE_LEVEL_STATUS,
	output logic            INT_REQ,
	output logic            WAKE_REQ,
	output logic            RESTART_REQ,
	output logic            BUCK_PWM_SEL,
	output logic            PULL_UP_EN,
	output logic            PULL_DOWN_EN
);
	typedef struct packed {
		logic [1:0] sync;
		logic       flag;
		logic       lvl_stat;
		logic       int_req;
		logic       wake_req;
		logic       restart_req;
		logic       pwm_sel;
		logic       pu;
		logic       pd;
	} wkdet_top_s;
	wkdet_top_s st_ff;
	wkdet_top_s nxt_st;

	logic        flt_level;
	logic        flt_edge;
	logic        pin_mode;
	logic        sense_on;
	logic        accept;
	logic [1:0]  bias_sel;
	wkdet_mode_e mode;

	wkdet_filter #(
		.FILTER_CYC (FILTER_CYC)
	) u_filter (
		.clk        (CLK),
		.rst_n      (RST_N),
		.pin_sync   (st_ff.sync[1]),
		.level      (flt_level),
		.edge_pulse (flt_edge)
	);

	always_comb begin
		mode = wkdet_mode_e'(POWER_MODE);
		bias_sel = {BIAS_SELECT_HIGH_BIT, BIAS_SELECT_LOW_BIT};
		pin_mode = BUCK_MODE_BY_PIN_SEL && (mode == WKDET_STOP);
		// Cyclic sensing accepts filtered edges only while the window is open
		sense_on = !CYCLIC_SENSE || CYCLIC_WINDOW;
		// Selector use is a control line, not a wake source
		accept = flt_edge && WAKE_PIN_ENABLE && sense_on && !pin_mode;
		nxt_st = st_ff;
		nxt_st.sync = {st_ff.sync[0], WAKE_PIN};
		nxt_st.int_req = 1'b0;
		nxt_st.wake_req = 1'b0;
		nxt_st.restart_req = 1'b0;
		if (accept) begin
			case (mode)
				WKDET_NORMAL, WKDET_STOP: nxt_st.int_req = 1'b1;
				WKDET_SLEEP: nxt_st.wake_req = 1'b1;
				WKDET_FAILSAFE: begin
					nxt_st.wake_req = 1'b1;
					nxt_st.restart_req = 1'b1;
				end
				default: nxt_st.int_req = 1'b0;
			endcase
		end
		// Set wins over a clear in the same cycle
		if (accept) begin
			nxt_st.flag = 1'b1;
		end else if (WAKE_FLAG_CLEAR) begin
			nxt_st.flag = 1'b0;
		end
		// Level status has no path into the interrupt
		if (mode == WKDET_NORMAL || mode == WKDET_STOP) begin
			nxt_st.lvl_stat = flt_level;
		end
		if (pin_mode) begin
			nxt_st.pwm_sel = st_ff.sync[1];
		end
		case (bias_sel)
			`WKDET_BIAS_NONE: begin
				nxt_st.pu = 1'b0;
				nxt_st.pd = 1'b0;
			end
			`WKDET_BIAS_PD: begin
				nxt_st.pu = 1'b0;
				nxt_st.pd = 1'b1;
			end
			`WKDET_BIAS_PU: begin
				nxt_st.pu = 1'b1;
				nxt_st.pd = 1'b0;
			end
			`WKDET_BIAS_AUTO: begin
				nxt_st.pu = flt_level;
				nxt_st.pd = !flt_level;
			end
			default: begin
				nxt_st.pu = 1'b0;
				nxt_st.pd = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign WAKE_PIN_EVENT_FLAG = st_ff.flag;
	assign WAKE_LEVEL_STATUS   = st_ff.lvl_stat;
	assign INT_REQ             = st_ff.int_req;
	assign WAKE_REQ            = st_ff.wake_req;
	assign RESTART_REQ         = st_ff.restart_req;
	assign BUCK_PWM_SEL        = st_ff.pwm_sel;
	assign PULL_UP_EN          = st_ff.pu;
	assign PULL_DOWN_EN        = st_ff.pd;
endmodule : wkdet_top
`default_nettype wire

// [wkdet_consts.svh]
// Constants for the wake input detector
`ifndef WKDET_CONSTS_SVH
`define WKDET_CONSTS_SVH
`define WKDET_CLK_MHZ        125
`define WKDET_FILTER_US      16
`define WKDET_FILTER_CYC     (`WKDET_FILTER_US * `WKDET_CLK_MHZ)
`define WKDET_BIAS_NONE      2'h0
`define WKDET_BIAS_PD        2'h1
`define WKDET_BIAS_PU        2'h2
`define WKDET_BIAS_AUTO      2'h3
`define WKDET_MODE_NORMAL    2'h0
`define WKDET_MODE_STOP      2'h1
`define WKDET_MODE_SLEEP     2'h2
`define WKDET_MODE_FAILSAFE  2'h3
`endif

// [wkdet_pkg.sv]
// Types for the wake input detector
package wkdet_pkg;
	typedef enum logic [1:0] {
		WKDET_NORMAL   = 2'h0,
		WKDET_STOP     = 2'h1,
		WKDET_SLEEP    = 2'h2,
		WKDET_FAILSAFE = 2'h3
	} wkdet_mode_e;
	typedef enum logic [0:0] {
		WKDET_IDLE = 1'h0,
		WKDET_QUAL = 1'h1
	} wkdet_flt_e;
endpackage : wkdet_pkg

// [wkdet_filter.sv]
// Edge filter: accepts a new level only after it stays stable
`timescale 1ns/10ps
`default_nettype none
`include "wkdet_consts.svh"
module wkdet_filter
	import wkdet_pkg::*;
#(
	parameter int FILTER_CYC = `WKDET_FILTER_CYC
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin_sync,
	output logic      level,
	output logic      edge_pulse
);
	localparam int CW = $clog2(FILTER_CYC + 1);
	typedef struct packed {
		wkdet_flt_e    st;
		logic [CW-1:0] cnt;
		logic          level;
		logic          edge_pulse;
	} wkdet_flt_s;
	wkdet_flt_s st_ff;
	wkdet_flt_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.edge_pulse = 1'b0;
		case (st_ff.st)
			WKDET_IDLE: begin
				if (pin_sync != st_ff.level) begin
					nxt_st.st = WKDET_QUAL;
					nxt_st.cnt = CW'(1);
				end
			end
			WKDET_QUAL: begin
				if (pin_sync == st_ff.level) begin
					// Reverted early: drop the candidate
					nxt_st.st = WKDET_IDLE;
				end else if (st_ff.cnt >= CW'(FILTER_CYC - 1)) begin
					nxt_st.st = WKDET_IDLE;
					nxt_st.level = pin_sync;
					nxt_st.edge_pulse = 1'b1;
				end else begin
					nxt_st.cnt = st_ff.cnt + CW'(1);
				end
			end
			default: nxt_st.st = WKDET_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign level = st_ff.level;
	assign edge_pulse = st_ff.edge_pulse;
endmodule : wkdet_filter
`default_nettype wire

// [wkdet_properties.sv]
// Checker for the wake input detector outputs
`timescale 1ns/10ps
`default_nettype none
module wkdet_props (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic WAKE_FLAG_CLEAR,
	input wire logic WAKE_PIN_EVENT_FLAG,
	input wire logic INT_REQ,
	input wire logic WAKE_REQ,
	input wire logic RESTART_REQ,
	input wire logic PULL_UP_EN,
	input wire logic PULL_DOWN_EN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	property p_int; INT_REQ |-> !WAKE_REQ; endproperty
	a_int: assert property (p_int) else $error("int with wake");
	property p_rst; RESTART_REQ |-> WAKE_REQ; endproperty
	a_rst: assert property (p_rst) else $error("restart alone");
	property p_flag; INT_REQ || WAKE_REQ |-> WAKE_PIN_EVENT_FLAG; endproperty
	a_flag: assert property (p_flag) else $error("flag not set");
	property p_hold; $fell(WAKE_PIN_EVENT_FLAG) |-> $past(WAKE_FLAG_CLEAR); endproperty
	a_hold: assert property (p_hold) else $error("flag lost");
	property p_bias; !(PULL_UP_EN && PULL_DOWN_EN); endproperty
	a_bias: assert property (p_bias) else $error("both pulls");
	property p_gap; INT_REQ |=> !INT_REQ [*7]; endproperty
	a_gap: assert property (p_gap) else $error("int too close");
endmodule : wkdet_props
bind wkdet_top wkdet_props chk_i (.*);
`default_nettype wire

// [wkdet_switch.sv]
// External switch model: drives the pin DLY cycles after command
`timescale 1ns/10ps
`default_nettype none
module wkdet_switch #(parameter int DLY = 1) (
	input  wire logic clk,
	input  wire logic cmd,
	output logic      pin
);
	logic [7:0] sh    = 8'h00;
	logic       cmd_q = 1'b0;
	// Taken at the rise so the falling-edge shift never races the bench
	always @(posedge clk) cmd_q <= cmd;
	always @(negedge clk) sh <= {sh[6:0], cmd_q};
	assign pin = sh[DLY-1];
endmodule : wkdet_switch
`default_nettype wire

// [tb.sv]
// Testbench for the wake input detector
`timescale 1ns/10ps
`default_nettype none
module tb;
	import wkdet_pkg::*;
	logic CLK = 0, RST_N = 0, cmd = 0, pin, en = 1, cyc = 0, sel = 0;
	logic bh = 0, bl = 0, clr = 0, flg, lvl, irq, wrq, rrq, pwm, pu, pd;
	logic win = 0;
	logic [1:0] md = WKDET_NORMAL;
	int err_count = 0, n_checks = 0;
	always #4 CLK = ~CLK;
	wkdet_switch #(.DLY(1)) sw (.clk(CLK), .cmd(cmd), .pin(pin));
	wkdet_top #(.FILTER_CYC(8)) uut (.CLK(CLK), .RST_N(RST_N),
		.WAKE_PIN(pin), .POWER_MODE(md), .WAKE_PIN_ENABLE(en),
		.CYCLIC_SENSE(cyc), .CYCLIC_WINDOW(win),
		.BUCK_MODE_BY_PIN_SEL(sel), .BIAS_SELECT_HIGH_BIT(bh),
		.BIAS_SELECT_LOW_BIT(bl), .WAKE_FLAG_CLEAR(clr),
		.WAKE_PIN_EVENT_FLAG(flg), .WAKE_LEVEL_STATUS(lvl),
		.INT_REQ(irq), .WAKE_REQ(wrq), .RESTART_REQ(rrq),
		.BUCK_PWM_SEL(pwm), .PULL_UP_EN(pu), .PULL_DOWN_EN(pd));
	task chk(input logic [3:0] s, input logic [3:0] e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	// Collects request pulses over a bounded span after a pin move
	task go(input logic l, input logic [2:0] e);
		logic [2:0] s;
		s = 3'h0;
		cmd = l;
		repeat (20) begin
			@(negedge CLK);
			s |= {irq, wrq, rrq};
		end
		chk(s, e);
		$display("test done at %0t", $time);
	endtask : go
	initial begin
		repeat (10) @(negedge CLK);
		chk({pu, pd, flg, irq}, 4'h0);
		RST_N = 1;
		bh = 1;
		bl = 1;
		go(1, 3'h4);
		chk({flg, lvl, pu, pd}, 4'he);
		go(0, 3'h4);
		chk({lvl, pu, pd}, 4'h1);
		clr = 1;
		@(negedge CLK);
		clr = 0;
		@(negedge CLK);
		chk(flg, 4'h0);
		// Pulse shorter than the filter must vanish
		cmd = 1;
		repeat (4) @(negedge CLK);
		go(0, 3'h0);
		en = 0;
		go(1, 3'h0);
		en = 1;
		cyc = 1;
		go(0, 3'h0);
		win = 1;
		go(1, 3'h4);
		cyc = 0;
		win = 0;
		md = WKDET_SLEEP;
		go(0, 3'h2);
		chk(lvl, 4'h1);
		md = WKDET_FAILSAFE;
		go(1, 3'h3);
		md = WKDET_STOP;
		sel = 1;
		repeat (5) @(negedge CLK);
		chk(pwm, 4'h1);
		cmd = 0;
		repeat (5) @(negedge CLK);
		chk(pwm, 4'h0);
		go(0, 3'h0);
		bl = 0;
		@(negedge CLK);
		chk({pu, pd}, 4'h2);
		bh = 0;
		bl = 1;
		@(negedge CLK);
		chk({pu, pd}, 4'h1);
		bl = 0;
		@(negedge CLK);
		chk({pu, pd}, 4'h0);
		end_sim;
	end
endmodule : tb
`default_nettype wire
